// ==== hdl/usfe_consts.vh ====
// Constants for the serial port status flag block: register offsets,
// field positions, reset values and receive FIFO sizing.
// Assumes byte addresses on a 32-bit classic Wishbone bus.
`ifndef USFE_CONSTS_VH
`define USFE_CONSTS_VH

////////////////////////////////////////////////////////////////////////////////
// Register byte offsets
`define USFE_ADR_CTRL 8'h00
`define USFE_ADR_DATA 8'h14
`define USFE_ADR_STAT0 8'h1C
`define USFE_ADR_STAT1 8'h20

////////////////////////////////////////////////////////////////////////////////
// Control register fields
`define USFE_CTRL_PAR_EN 0
`define USFE_CTRL_PAR_ODD 1
`define USFE_CTRL_TX_EN 2
`define USFE_CTRL_RESET 3'h0

// serial_line_status_second fields
`define USFE_ST1_TX_BUSY 0
`define USFE_ST1_RX_AVAIL 1
`define USFE_ST1_TX_ROOM 2
`define USFE_ST1_PAR_ERR 3
`define USFE_ST1_FRM_ERR 4
`define USFE_ST1_RX_OVR 5
`define USFE_ST1_RESET 8'h04

// First status register fields
`define USFE_ST0_ERR_SUM 0
`define USFE_ST0_CNT_LSB 4
`define USFE_ST0_CNT_MSB 7

////////////////////////////////////////////////////////////////////////////////
// FIFO sizing and tags
`define USFE_FIFO_DEPTH 4'h8
`define USFE_ERR_WINDOW 4'h4
`define USFE_REQ_MIN 4'h5
`define USFE_REQ_MAX 4'h8
`define USFE_TAG_PAR 0
`define USFE_TAG_FRM 1
`define USFE_TAG_OVR 2

`endif

// ==== hdl/usfe_mem.v ====
// Eight-entry storage for one FIFO, one write and one read port.
// Read data comes out of a register; a write to the slot being read
// is passed straight through so a fresh byte is seen at once.
`timescale 1ns/1ps
`include "usfe_consts.vh"

module usfe_mem #(
  parameter WIDTH = 8
) (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wr_en_i,
  input wire [2:0] wr_addr_i,
  input wire [WIDTH-1:0] wr_data_i,
  input wire [2:0] rd_addr_i,
  output reg [WIDTH-1:0] rd_data_o
);

  reg [WIDTH-1:0] mem_q [0:7];

  ////////////////////////////////////////////////////////////////////////////////
  // Storage itself carries no reset, only the read register does
  always @(posedge clk_i) begin
    if (ce_i && wr_en_i) begin
      mem_q[wr_addr_i] <= wr_data_i;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      rd_data_o <= {WIDTH{1'b0}};
    end else if (ce_i) begin
      if (wr_en_i && (wr_addr_i == rd_addr_i)) begin
        rd_data_o <= wr_data_i;
      end else begin
        rd_data_o <= mem_q[rd_addr_i];
      end
    end
  end

endmodule // usfe_mem

// ==== hdl/usfe_rx_check.v ====
// Checks each byte from the receive shifter for parity and framing
// errors and hands it on one cycle later with its two error tags.
// Assumes rx_valid_i is a one-cycle pulse per received frame.
`timescale 1ns/1ps
`include "usfe_consts.vh"

module usfe_rx_check (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire parity_enable_i,
  input wire odd_even_select_i,
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  input wire rx_parity_i,
  input wire rx_stop_i,
  output reg byte_valid_o,
  output reg [7:0] byte_data_o,
  output reg parity_tag_o,
  output reg framing_tag_o
);

  // High when data plus parity bit hold an odd count of ones
  wire ones_odd = ^{rx_data_i, rx_parity_i};

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (rst_i) begin
      byte_valid_o <= 1'b0;
      byte_data_o <= 8'h00;
      parity_tag_o <= 1'b0;
      framing_tag_o <= 1'b0;
    end else if (ce_i) begin
      byte_valid_o <= rx_valid_i;
      if (rx_valid_i) begin
        byte_data_o <= rx_data_i;
        // Odd parity flags an odd count of ones as an error, even parity flags an even count
        parity_tag_o <= parity_enable_i & (odd_even_select_i ? ones_odd : ~ones_odd);
        framing_tag_o <= ~rx_stop_i;
      end
    end
  end

endmodule // usfe_rx_check

// ==== hdl/usfe_status.v ====
// Serial port status flags with per-byte error tags in the receive FIFO.
// Assumes a classic Wishbone master, a receive shifter that pulses
// rx_valid_i per frame and a transmit shifter that takes bytes here.
`timescale 1ns/1ps
`include "usfe_consts.vh"

module usfe_status (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  input wire rx_parity_i,
  input wire rx_stop_i,
  output wire [7:0] tx_data_o,
  output reg tx_valid_o,
  input wire tx_take_i,
  input wire tx_done_i,
  output reg rx_service_req_o,
  output reg rx_irq_o
);

  ////////////////////////////////////////////////////////////////////////////////
  // State
  reg parity_enable_q;
  reg odd_even_select_q;
  reg transmit_enable_q;
  reg transmit_busy_flag_q;
  reg transmit_busy_flag_d;
  reg parity_error_flag_q;
  reg parity_error_flag_d;
  reg framing_error_flag_q;
  reg framing_error_flag_d;
  reg rx_overrun_flag_q;
  reg rx_overrun_flag_d;
  reg [2:0] rx_wr_ptr_q;
  reg [2:0] rx_rd_ptr_q;
  reg [3:0] rx_count_q;
  reg [3:0] rx_count_d;
  reg [2:0] tx_wr_ptr_q;
  reg [2:0] tx_rd_ptr_q;
  reg [3:0] tx_count_q;
  reg [3:0] tx_count_d;
  reg [31:0] rd_d;
  reg error_in_fifo;
  reg [2:0] err_idx;
  reg [3:0] k;

  wire chk_valid;
  wire [7:0] chk_data;
  wire chk_par;
  wire chk_frm;
  wire [7:0] rx_rdata;
  wire [23:0] tags_w;

  ////////////////////////////////////////////////////////////////////////////////
  // Bus decode; one request per ack, ack one cycle after request
  wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire acc_data = req & (wb_adr_i == `USFE_ADR_DATA);
  wire acc_ctrl = req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `USFE_ADR_CTRL);
  wire rx_fifo_not_empty = (rx_count_q != 4'h0);
  wire tx_fifo_not_full = (tx_count_q != `USFE_FIFO_DEPTH);
  wire rx_full = (rx_count_q == `USFE_FIFO_DEPTH);
  wire rx_pop = acc_data & ~wb_we_i & rx_fifo_not_empty;
  // A pop in the same cycle frees a slot, so the byte still fits
  wire rx_push = chk_valid & (~rx_full | rx_pop);
  wire rx_ovr = chk_valid & rx_full & ~rx_pop;
  wire [2:0] rx_top_ptr = rx_wr_ptr_q - 3'h1;
  wire [2:0] rx_rd_ptr_d = rx_pop ? rx_rd_ptr_q + 3'h1 : rx_rd_ptr_q;
  // Bytes written to a full transmit FIFO are dropped
  wire tx_push = acc_data & wb_we_i & wb_sel_i[0] & tx_fifo_not_full;
  wire tx_pop = tx_take_i & tx_valid_o;
  wire [2:0] tx_rd_ptr_d = tx_pop ? tx_rd_ptr_q + 3'h1 : tx_rd_ptr_q;
  wire [2:0] next_bot = rx_rd_ptr_q + 3'h1;
  wire [2:0] next_tag = tags_w[3*next_bot +: 3];
  wire tx_enable_d = acc_ctrl ? wb_dat_i[`USFE_CTRL_TX_EN] : transmit_enable_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Submodules
  usfe_rx_check u_rx_check (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .parity_enable_i(parity_enable_q),
    .odd_even_select_i(odd_even_select_q),
    .rx_valid_i(rx_valid_i),
    .rx_data_i(rx_data_i),
    .rx_parity_i(rx_parity_i),
    .rx_stop_i(rx_stop_i),
    .byte_valid_o(chk_valid),
    .byte_data_o(chk_data),
    .parity_tag_o(chk_par),
    .framing_tag_o(chk_frm)
  );

  usfe_mem #(.WIDTH(8)) u_rx_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_en_i(rx_push),
    .wr_addr_i(rx_wr_ptr_q),
    .wr_data_i(chk_data),
    .rd_addr_i(rx_rd_ptr_d),
    .rd_data_o(rx_rdata)
  );

  usfe_mem #(.WIDTH(8)) u_tx_mem (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .wr_en_i(tx_push),
    .wr_addr_i(tx_wr_ptr_q),
    .wr_data_i(wb_dat_i[7:0]),
    .rd_addr_i(tx_rd_ptr_d),
    .rd_data_o(tx_data_o)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Hidden tags, three per receive entry
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_tag
      localparam [2:0] IDX = g;
      reg [2:0] tag_q;
      always @(posedge clk_i) begin
        if (rst_i) begin
          tag_q <= 3'h0;
        end else if (ce_i) begin
          if (rx_push && (rx_wr_ptr_q == IDX)) begin
            tag_q <= {1'b0, chk_frm, chk_par};
          end else if (rx_ovr && (rx_top_ptr == IDX)) begin
            // Marks the last good byte before the lost one
            tag_q[`USFE_TAG_OVR] <= 1'b1;
          end
        end
      end
      assign tags_w[3*g +: 3] = tag_q;
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Error in FIFO over the four oldest held bytes
  always @* begin
    error_in_fifo = 1'b0;
    err_idx = 3'h0;
    for (k = 4'h0; k < `USFE_ERR_WINDOW; k = k + 4'h1) begin
      err_idx = rx_rd_ptr_q + k[2:0];
      if ((k < rx_count_q) && (tags_w[3*err_idx +: 3] != 3'h0)) begin
        error_in_fifo = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Counts
  always @* begin
    rx_count_d = rx_count_q;
    if (rx_push && !rx_pop) begin
      rx_count_d = rx_count_q + 4'h1;
    end else if (rx_pop && !rx_push) begin
      rx_count_d = rx_count_q - 4'h1;
    end
    tx_count_d = tx_count_q;
    if (tx_push && !tx_pop) begin
      tx_count_d = tx_count_q + 4'h1;
    end else if (tx_pop && !tx_push) begin
      tx_count_d = tx_count_q - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Bottom-entry flags follow whichever byte now sits at the bottom
  always @* begin
    parity_error_flag_d = parity_error_flag_q;
    framing_error_flag_d = framing_error_flag_q;
    rx_overrun_flag_d = rx_overrun_flag_q;
    if (rx_pop && (rx_count_q > 4'h1)) begin
      parity_error_flag_d = next_tag[`USFE_TAG_PAR];
      framing_error_flag_d = next_tag[`USFE_TAG_FRM];
      rx_overrun_flag_d = next_tag[`USFE_TAG_OVR];
    end else if (rx_push && ((rx_count_q == 4'h0) || rx_pop)) begin
      // Incoming byte lands straight at the bottom
      parity_error_flag_d = chk_par;
      framing_error_flag_d = chk_frm;
      rx_overrun_flag_d = 1'b0;
    end else if (rx_pop) begin
      // FIFO drained; no byte left to describe
      parity_error_flag_d = 1'b0;
      framing_error_flag_d = 1'b0;
      rx_overrun_flag_d = 1'b0;
    end
  end

  // Busy: a new load wins over a finishing frame; disable clears it
  always @* begin
    transmit_busy_flag_d = transmit_busy_flag_q;
    if (!tx_enable_d) begin
      transmit_busy_flag_d = 1'b0;
    end else if (tx_pop) begin
      transmit_busy_flag_d = 1'b1;
    end else if (tx_done_i) begin
      transmit_busy_flag_d = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data; status bits are read-only and writes there are ignored
  always @* begin
    rd_d = 32'h0000_0000;
    case (wb_adr_i)
      `USFE_ADR_CTRL: begin
        rd_d[`USFE_CTRL_PAR_EN] = parity_enable_q;
        rd_d[`USFE_CTRL_PAR_ODD] = odd_even_select_q;
        rd_d[`USFE_CTRL_TX_EN] = transmit_enable_q;
      end
      `USFE_ADR_DATA: begin
        if (rx_fifo_not_empty) begin
          rd_d[7:0] = rx_rdata;
        end
      end
      `USFE_ADR_STAT0: begin
        rd_d[`USFE_ST0_ERR_SUM] = error_in_fifo;
        rd_d[`USFE_ST0_CNT_MSB:`USFE_ST0_CNT_LSB] = rx_count_q;
      end
      `USFE_ADR_STAT1: begin
        rd_d[`USFE_ST1_TX_BUSY] = transmit_busy_flag_q;
        rd_d[`USFE_ST1_RX_AVAIL] = rx_fifo_not_empty;
        rd_d[`USFE_ST1_TX_ROOM] = tx_fifo_not_full;
        rd_d[`USFE_ST1_PAR_ERR] = parity_error_flag_q;
        rd_d[`USFE_ST1_FRM_ERR] = framing_error_flag_q;
        rd_d[`USFE_ST1_RX_OVR] = rx_overrun_flag_q;
      end
      default: begin
        rd_d = 32'h0000_0000;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      parity_enable_q <= 1'b0;
      odd_even_select_q <= 1'b0;
      transmit_enable_q <= 1'b0;
      transmit_busy_flag_q <= 1'b0;
      parity_error_flag_q <= 1'b0;
      framing_error_flag_q <= 1'b0;
      rx_overrun_flag_q <= 1'b0;
      rx_wr_ptr_q <= 3'h0;
      rx_rd_ptr_q <= 3'h0;
      rx_count_q <= 4'h0;
      tx_wr_ptr_q <= 3'h0;
      tx_rd_ptr_q <= 3'h0;
      tx_count_q <= 4'h0;
      tx_valid_o <= 1'b0;
      rx_service_req_o <= 1'b0;
      rx_irq_o <= 1'b0;
    end else if (ce_i) begin
      wb_ack_o <= req;
      if (req) begin
        wb_dat_o <= wb_we_i ? 32'h0000_0000 : rd_d;
      end
      if (acc_ctrl) begin
        parity_enable_q <= wb_dat_i[`USFE_CTRL_PAR_EN];
        odd_even_select_q <= wb_dat_i[`USFE_CTRL_PAR_ODD];
        transmit_enable_q <= wb_dat_i[`USFE_CTRL_TX_EN];
      end
      transmit_busy_flag_q <= transmit_busy_flag_d;
      parity_error_flag_q <= parity_error_flag_d;
      framing_error_flag_q <= framing_error_flag_d;
      rx_overrun_flag_q <= rx_overrun_flag_d;
      if (rx_push) begin
        rx_wr_ptr_q <= rx_wr_ptr_q + 3'h1;
      end
      rx_rd_ptr_q <= rx_rd_ptr_d;
      rx_count_q <= rx_count_d;
      if (tx_push) begin
        tx_wr_ptr_q <= tx_wr_ptr_q + 3'h1;
      end
      tx_rd_ptr_q <= tx_rd_ptr_d;
      tx_count_q <= tx_count_d;
      // Offer a byte only when the shifter may actually load it
      tx_valid_o <= (tx_count_d != 4'h0) & tx_enable_d & ~transmit_busy_flag_d;
      // Requests lag the FIFO state by one cycle; of the status flags only the error summary feeds them
      rx_service_req_o <= (rx_count_q >= `USFE_REQ_MIN) & (rx_count_q <= `USFE_REQ_MAX) & ~error_in_fifo;
      rx_irq_o <= ((rx_count_q >= `USFE_REQ_MIN) & (rx_count_q <= `USFE_REQ_MAX)) | error_in_fifo;
    end
  end

endmodule // usfe_status

// ==== testbench/usfe_status_monitor.sv ====
// Concurrent checks on the serial status block ports.
// Assumes one clock and a synchronous active high reset.
`timescale 1ns/1ps
`include "usfe_consts.vh"
module usfe_status_monitor (
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  input wire rx_valid_i,
  input wire [7:0] rx_data_i,
  input wire rx_parity_i,
  input wire rx_stop_i,
  input wire [7:0] tx_data_o,
  input wire tx_valid_o,
  input wire tx_take_i,
  input wire tx_done_i,
  input wire rx_service_req_o,
  input wire rx_irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
  ////////////////////////////////////////////////////////////////////////////////
  chk_ack_next: assert property (req |=> wb_ack_o)
    else $error("ack not one cycle after request");
  chk_ack_single: assert property (wb_ack_o && ce_i |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  chk_stat_upper: assert property (req && !wb_we_i && wb_adr_i == `USFE_ADR_STAT1 |=> wb_dat_o[31:6] == 26'h0)
    else $error("reserved status bits not zero");
  chk_unmapped_zero: assert property (req && !wb_we_i && wb_adr_i == 8'h10 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  chk_write_zero: assert property (req && wb_we_i |=> wb_dat_o == 32'h0)
    else $error("write returned data");
  chk_svc_irq: assert property (rx_service_req_o |-> rx_irq_o)
    else $error("service request without interrupt");
  chk_take_drop: assert property (tx_take_i && tx_valid_o && ce_i |=> !tx_valid_o)
    else $error("offer kept after take");
  chk_busy_hold: assert property ((tx_take_i && tx_valid_o) ##1 (!tx_done_i) [*4] |-> !tx_valid_o)
    else $error("new offer while shifter busy");
  chk_reset_quiet: assert property ($fell(rst_i) |-> !rx_service_req_o && !rx_irq_o && !tx_valid_o && !wb_ack_o)
    else $error("outputs active after reset");
endmodule // usfe_status_monitor

bind usfe_status usfe_status_monitor chk (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_valid_i(rx_valid_i), .rx_data_i(rx_data_i),
  .rx_parity_i(rx_parity_i), .rx_stop_i(rx_stop_i), .tx_data_o(tx_data_o), .tx_valid_o(tx_valid_o),
  .tx_take_i(tx_take_i), .tx_done_i(tx_done_i), .rx_service_req_o(rx_service_req_o), .rx_irq_o(rx_irq_o));

// ==== testbench/usfe_line_model.sv ====
// Far side of the line: receive shifter pulses and transmit shifter.
// Assumes the status block on the same clock.
`timescale 1ns/1ps
module usfe_line_model #(
  parameter FRAME_CYC = 12
) (
  input wire clk_i,
  input wire rst_i,
  input wire stall_i,
  input wire [7:0] tx_data_i,
  input wire tx_valid_i,
  output reg tx_take_o,
  output reg tx_done_o,
  output reg rx_valid_o,
  output reg [7:0] rx_data_o,
  output reg rx_parity_o,
  output reg rx_stop_o
);
  logic [7:0] got_q [$];
  integer busy_q;
  initial begin
    tx_take_o = 1'b0;
    tx_done_o = 1'b0;
    rx_valid_o = 1'b0;
    rx_data_o = 8'h00;
    rx_parity_o = 1'b0;
    rx_stop_o = 1'b1;
    busy_q = 0;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Lines are inverted after the pulse so stale values never pass
  task send(input [7:0] d, input p, input s);
    begin
      @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_data_o <= d;
      rx_parity_o <= p;
      rx_stop_o <= s;
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_data_o <= ~d;
      rx_parity_o <= ~p;
      rx_stop_o <= ~s;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    tx_done_o <= 1'b0;
    if (rst_i) begin
      tx_take_o <= 1'b0;
      busy_q <= 0;
    end else if (tx_take_o) begin
      tx_take_o <= 1'b0;
      if (tx_valid_i) got_q.push_back(tx_data_i);
      busy_q <= FRAME_CYC;
    end else if (busy_q > 1) begin
      busy_q <= busy_q - 1;
    end else if (busy_q == 1) begin
      busy_q <= 0;
      tx_done_o <= 1'b1;
    end else if (tx_valid_i && !stall_i) begin
      tx_take_o <= 1'b1;
    end
  end
endmodule // usfe_line_model

// ==== testbench/usfe_status_tb.sv ====
// Self-checking bench for the serial status flag block.
// Assumes the line model and the bound checker.
`timescale 1ns/1ps
`include "usfe_consts.vh"
module usfe_status_tb;
  reg clk_i, rst_i, cyc, stb, we, stall, ce;
  reg [3:0] sel;
  reg [7:0] adr;
  reg [31:0] wdat, r;
  wire [31:0] rdat;
  wire ack, rxv, rxp, rxs, txv, take, done, svc, irq;
  wire [7:0] rxd, txd;
  integer mismatches, checks_done, cyc_n, k;
  usfe_status dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .rx_valid_i(rxv),
    .rx_data_i(rxd), .rx_parity_i(rxp), .rx_stop_i(rxs), .tx_data_o(txd), .tx_valid_o(txv), .tx_take_i(take),
    .tx_done_i(done), .rx_service_req_o(svc), .rx_irq_o(irq));
  usfe_line_model line (.clk_i(clk_i), .rst_i(rst_i), .stall_i(stall), .tx_data_i(txd), .tx_valid_i(txv),
    .tx_take_o(take), .tx_done_o(done), .rx_valid_o(rxv), .rx_data_o(rxd), .rx_parity_o(rxp), .rx_stop_o(rxs));
  ////////////////////////////////////////////////////////////////////////////////
  task results;
    begin
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        mismatches = mismatches + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  // Classic cycle; the wait is bounded by the global timeout
  task wb(input w, input [7:0] a, input [31:0] d);
    begin
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      @(posedge clk_i);
      while (ack !== 1'b1) @(posedge clk_i);
      r = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
    end
  endtask
  task chk(input [7:0] a, input [31:0] exp);
    begin
      wb(1'b0, a, 32'h0);
      cmp(r, exp);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task t_reset;
    begin
      chk(`USFE_ADR_STAT1, 32'h04);
      wb(1'b1, `USFE_ADR_STAT1, 32'hFF);
      chk(`USFE_ADR_STAT1, 32'h04);
      // Control write without its byte lane must not land
      sel <= 4'hE;
      wb(1'b1, `USFE_ADR_CTRL, 32'h7);
      sel <= 4'hF;
      chk(`USFE_ADR_CTRL, 32'h0);
      chk(`USFE_ADR_DATA, 32'h0);
      chk(8'h10, 32'h0);
      $display("test reset done");
    end
  endtask
  // A frame arriving while the clock enable is low leaves no trace
  task t_freeze;
    begin
      ce <= 1'b0;
      line.send(8'h5A, 1'b0, 1'b0);
      @(posedge clk_i);
      ce <= 1'b1;
      repeat (3) @(posedge clk_i);
      chk(`USFE_ADR_STAT0, 32'h0);
      chk(`USFE_ADR_STAT1, 32'h04);
      $display("test freeze done");
    end
  endtask
  task t_parity;
    reg [7:0] d;
    reg par_en, par_odd, p, s, e;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        d = 8'h35 + k[7:0];
        par_en = k[0];
        par_odd = k[1];
        p = k[2];
        s = (k != 6);
        wb(1'b1, `USFE_ADR_CTRL, {30'h0, par_odd, par_en});
        line.send(d, p, s);
        repeat (3) @(posedge clk_i);
        e = par_en & (par_odd ? ^{d, p} : ~^{d, p});
        chk(`USFE_ADR_STAT1, {26'h0, 1'b0, ~s, e, 3'b110});
        chk(`USFE_ADR_DATA, {24'h0, d});
        chk(`USFE_ADR_STAT1, 32'h04);
      end
      $display("test parity done");
    end
  endtask
  // Read status before data each time the error summary is up
  task t_tags;
    begin
      wb(1'b1, `USFE_ADR_CTRL, 32'h1);
      line.send(8'h01, 1'b0, 1'b1);
      line.send(8'h03, 1'b0, 1'b1);
      line.send(8'h01, 1'b0, 1'b0);
      repeat (3) @(posedge clk_i);
      chk(`USFE_ADR_STAT0, 32'h31);
      cmp({30'h0, svc, irq}, 32'h1);
      chk(`USFE_ADR_STAT1, 32'h06);
      chk(`USFE_ADR_DATA, 32'h01);
      chk(`USFE_ADR_STAT1, 32'h0E);
      chk(`USFE_ADR_DATA, 32'h03);
      chk(`USFE_ADR_STAT1, 32'h16);
      chk(`USFE_ADR_DATA, 32'h01);
      $display("test tags done");
    end
  endtask
  task t_thresh;
    begin
      wb(1'b1, `USFE_ADR_CTRL, 32'h0);
      for (k = 0; k < 9; k = k + 1) begin
        line.send(8'h40 + k[7:0], 1'b0, 1'b1);
        repeat (3) @(posedge clk_i);
        cmp({30'h0, svc, irq}, (k >= 4) ? 32'h3 : 32'h0);
      end
      for (k = 0; k < 8; k = k + 1) begin
        chk(`USFE_ADR_STAT1, (k == 7) ? 32'h26 : 32'h06);
        cmp({30'h0, svc, irq}, (k >= 4) ? 32'h1 : 32'h3);
        chk(`USFE_ADR_DATA, {24'h0, 8'h40 + k[7:0]});
      end
      chk(`USFE_ADR_STAT1, 32'h04);
      $display("test threshold done");
    end
  endtask
  // Shifter stalls so the transmit queue can be filled to refusal
  task t_tx;
    begin
      wb(1'b1, `USFE_ADR_CTRL, 32'h4);
      stall <= 1'b1;
      for (k = 0; k < 9; k = k + 1) begin
        wb(1'b1, `USFE_ADR_DATA, {24'h0, 8'h60 + k[7:0]});
        if (k >= 6) chk(`USFE_ADR_STAT1, (k == 6) ? 32'h04 : 32'h00);
      end
      stall <= 1'b0;
      repeat (4) @(posedge clk_i);
      chk(`USFE_ADR_STAT1, 32'h05);
      wb(1'b1, `USFE_ADR_CTRL, 32'h0);
      chk(`USFE_ADR_STAT1, 32'h04);
      wb(1'b1, `USFE_ADR_CTRL, 32'h4);
      repeat (300) @(posedge clk_i);
      chk(`USFE_ADR_STAT1, 32'h04);
      cmp(line.got_q.size(), 32'd8);
      for (k = 0; k < 8; k = k + 1) cmp({24'h0, line.got_q[k]}, {24'h0, 8'h60 + k[7:0]});
      $display("test transmit done");
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc_n = cyc_n + 1;
    if (cyc_n == 8000) begin
      mismatches = mismatches + 1;
      results;
    end
  end
  initial begin
    rst_i = 1'b1;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    stall = 1'b0;
    ce = 1'b1;
    sel = 4'hF;
    adr = 8'h00;
    wdat = 32'h0;
    mismatches = 0;
    checks_done = 0;
    cyc_n = 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset;
    t_freeze;
    t_parity;
    t_tags;
    t_thresh;
    t_tx;
    results;
  end
endmodule // usfe_status_tb
